/* rtl/sfd_decoder.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sfd_map.svh"
module sfd_decoder
(
   input wire logic clock,
   input wire logic rst_b,
   input wire logic sclk,
   input wire logic cs_b,
   input wire logic [3:0] sioIn,
   output logic [3:0] sioOut,
   output logic [3:0] sioOe,
   input wire logic [1:0] dummySel,
   input wire logic [7:0] readByte,
   output logic quadMode,
   output logic cmdValid,
   output sfd_pkg::sfd_req_t cmdReq,
   output logic cmdReject,
   output logic pauseReq,
   output logic continueReq,
   output logic memReset
);
   sfd_pkg::sfd_lnk_t lnkFf;
   sfd_pkg::sfd_lnk_t nxt_lnk;
   sfd_pkg::sfd_lnk_t base;
   sfd_pkg::sfd_drv_t drvFf;
   sfd_pkg::sfd_drv_t nxt_drv;
   sfd_pkg::sfd_core_t coreFf;
   sfd_pkg::sfd_core_t nxt_core;
   sfd_pkg::sfd_cmd_t decoded;
   sfd_pkg::sfd_lane_t lane;
   logic startedFf;
   logic frmRst_b;
   logic [1:0] dummySelSync;
   logic [7:0] readSync;
   logic csSync;
   logic [7:0] shifted;
   logic byteDone;
   logic frameEnd;
   logic complete;
   logic accept;

   function automatic logic [2:0] lastBit(input sfd_pkg::sfd_lane_t l);
      logic [2:0] r;
      r = `SFD_LAST_BIT_1;
      unique case (l)
         sfd_pkg::SFD_LN1: r = `SFD_LAST_BIT_1;
         sfd_pkg::SFD_LN2: r = `SFD_LAST_BIT_2;
         sfd_pkg::SFD_LN4: r = `SFD_LAST_BIT_4;
         default: r = `SFD_LAST_BIT_1;
      endcase
      return r;
   endfunction

   function automatic sfd_pkg::sfd_phase_t after(input sfd_pkg::sfd_cmd_t c,
      input logic pastAddr, input logic pastDummy);
      sfd_pkg::sfd_phase_t p;
      if (!pastAddr && c.addrBytes != `SFD_ADDR_NONE)
         p = sfd_pkg::SFD_PH_ADDR;
      else if (!pastDummy && c.dummy != `SFD_DUM_NONE)
         p = sfd_pkg::SFD_PH_DUMMY;
      else if (c.dir != sfd_pkg::SFD_DIR_NONE)
         p = sfd_pkg::SFD_PH_DATA;
      else
         p = sfd_pkg::SFD_PH_DONE;
      return p;
   endfunction

   assign frmRst_b = rst_b & ~cs_b;

   sfd_sync #(.WIDTH(2)) selSyncInst
   (
      .clock(sclk),
      .rst_b(rst_b),
      .din(dummySel),
      .dout(dummySelSync)
   );

   sfd_sync #(.WIDTH(8)) readSyncInst
   (
      .clock(sclk),
      .rst_b(rst_b),
      .din(readByte),
      .dout(readSync)
   );

   sfd_sync #(.WIDTH(1)) csSyncInst
   (
      .clock(clock),
      .rst_b(rst_b),
      .din(cs_b),
      .dout(csSync)
   );

   // frame marker, cleared while chip select is high
   always_ff @(posedge sclk or negedge frmRst_b)
   begin
      if (!frmRst_b)
         startedFf <= 1'b0;
      else
         startedFf <= 1'b1;
   end

   // link side: first edge of a frame starts from a clean slate
   always_comb
   begin
      base = lnkFf;
      if (!startedFf)
      begin
         base.phase = sfd_pkg::SFD_PH_CMD;
         base.frameTgl = ~lnkFf.frameTgl;
         base.bitCnt = 3'h0;
         base.byteCnt = 3'h0;
         base.dummyCnt = 5'h00;
         base.addr = 32'h0000_0000;
         base.dataCnt = 9'h000;
         base.cmd = '0;
      end
   end

   always_comb
   begin
      unique case (base.phase)
         sfd_pkg::SFD_PH_CMD: lane = coreFf.quad ? sfd_pkg::SFD_LN4 : sfd_pkg::SFD_LN1;
         sfd_pkg::SFD_PH_ADDR: lane = base.cmd.addrLanes;
         default: lane = base.cmd.dataLanes;
      endcase
   end

   always_comb
   begin
      unique case (lane)
         sfd_pkg::SFD_LN1: shifted = {lnkFf.wrData[6:0], sioIn[0]};
         sfd_pkg::SFD_LN2: shifted = {lnkFf.wrData[5:0], sioIn[1:0]};
         default: shifted = {lnkFf.wrData[3:0], sioIn[3:0]};
      endcase
      if (!startedFf || base.bitCnt == 3'h0)
      begin
         unique case (lane)
            sfd_pkg::SFD_LN1: shifted = {7'h00, sioIn[0]};
            sfd_pkg::SFD_LN2: shifted = {6'h00, sioIn[1:0]};
            default: shifted = {4'h0, sioIn[3:0]};
         endcase
      end
   end

   assign byteDone = base.bitCnt == lastBit(lane);

   sfd_cmd_table tableInst
   (
      .opcode(shifted),
      .quadMode(coreFf.quad),
      .dummySel(dummySelSync),
      .cmd(decoded)
   );

   always_comb
   begin
      nxt_lnk = base;
      nxt_lnk.wrData = shifted;
      if (base.phase != sfd_pkg::SFD_PH_IDLE && base.phase != sfd_pkg::SFD_PH_DUMMY)
         nxt_lnk.bitCnt = byteDone ? 3'h0 : 3'(base.bitCnt + 3'h1);
      unique case (base.phase)
         sfd_pkg::SFD_PH_CMD:
         begin
            if (byteDone)
            begin
               nxt_lnk.opcode = shifted;
               nxt_lnk.cmd = decoded;
               if (!decoded.known)
                  nxt_lnk.phase = sfd_pkg::SFD_PH_IDLE;
               else
                  nxt_lnk.phase = after(decoded, 1'b0, 1'b0);
            end
         end
         sfd_pkg::SFD_PH_ADDR:
         begin
            if (byteDone)
            begin
               nxt_lnk.addr = {base.addr[23:0], shifted};
               nxt_lnk.byteCnt = 3'(base.byteCnt + 3'h1);
               if (base.byteCnt == 3'(base.cmd.addrBytes - 3'h1))
                  nxt_lnk.phase = after(base.cmd, 1'b1, 1'b0);
            end
         end
         sfd_pkg::SFD_PH_DUMMY:
         begin
            nxt_lnk.dummyCnt = 5'(base.dummyCnt + 5'h01);
            if (base.dummyCnt == 5'(base.cmd.dummy - 5'h01))
               nxt_lnk.phase = after(base.cmd, 1'b1, 1'b1);
         end
         sfd_pkg::SFD_PH_DATA:
         begin
            if (byteDone && base.cmd.dir == sfd_pkg::SFD_DIR_IN)
            begin
               nxt_lnk.addr[7:0] = base.addr[7:0];
               nxt_lnk.dataCnt = (base.dataCnt == 9'h1FF) ? base.dataCnt :
                  9'(base.dataCnt + 9'h001);
            end
         end
         sfd_pkg::SFD_PH_DONE: nxt_lnk.phase = base.phase;
         sfd_pkg::SFD_PH_IDLE: nxt_lnk.phase = base.phase;
      endcase
   end

   always_ff @(posedge sclk or negedge rst_b)
   begin
      if (!rst_b)
         lnkFf <= '0;
      else
         lnkFf <= nxt_lnk;
   end

   // output stage on the falling edge, released when chip select rises
   always_comb
   begin
      nxt_drv = drvFf;
      nxt_drv.oe = 4'h0;
      nxt_drv.out = 4'h0;
      if (startedFf && lnkFf.phase == sfd_pkg::SFD_PH_DATA &&
         lnkFf.cmd.dir == sfd_pkg::SFD_DIR_OUT)
      begin
         nxt_drv.shift = (drvFf.cnt == 3'h0) ? readSync : drvFf.shift;
         nxt_drv.cnt = (drvFf.cnt == 3'h0) ? lastBit(lnkFf.cmd.dataLanes) :
            3'(drvFf.cnt - 3'h1);
         unique case (lnkFf.cmd.dataLanes)
            sfd_pkg::SFD_LN1:
            begin
               nxt_drv.out = {2'h0, nxt_drv.shift[7], 1'h0};
               nxt_drv.oe = 4'h2;
               nxt_drv.shift = {nxt_drv.shift[6:0], 1'h0};
            end
            sfd_pkg::SFD_LN2:
            begin
               nxt_drv.out = {2'h0, nxt_drv.shift[7:6]};
               nxt_drv.oe = 4'h3;
               nxt_drv.shift = {nxt_drv.shift[5:0], 2'h0};
            end
            default:
            begin
               nxt_drv.out = nxt_drv.shift[7:4];
               nxt_drv.oe = 4'hF;
               nxt_drv.shift = {nxt_drv.shift[3:0], 4'h0};
            end
         endcase
      end
   end

   always_ff @(negedge sclk or negedge frmRst_b)
   begin
      if (!frmRst_b)
         drvFf <= '0;
      else
         drvFf <= nxt_drv;
   end

   // core side: frame outcome judged once chip select is back high
   assign frameEnd = csSync && !coreFf.csPrev && (lnkFf.frameTgl != coreFf.seenTgl);
   assign complete = lnkFf.phase == sfd_pkg::SFD_PH_DATA ||
      lnkFf.phase == sfd_pkg::SFD_PH_DONE ||
      (!lnkFf.cmd.alignReq && lnkFf.phase == sfd_pkg::SFD_PH_DUMMY);
   assign accept = complete && (!lnkFf.cmd.alignReq || lnkFf.bitCnt == 3'h0);

   always_comb
   begin
      nxt_core = coreFf;
      nxt_core.csPrev = csSync;
      nxt_core.cmdValid = 1'b0;
      nxt_core.reject = 1'b0;
      nxt_core.pause = 1'b0;
      nxt_core.cont = 1'b0;
      nxt_core.memReset = 1'b0;
      if (frameEnd)
      begin
         nxt_core.seenTgl = lnkFf.frameTgl;
         if (lnkFf.phase != sfd_pkg::SFD_PH_CMD)
         begin
            nxt_core.armed = 1'b0;
            nxt_core.reject = !accept;
         end
         if (accept)
         begin
            nxt_core.cmdValid = 1'b1;
            nxt_core.req.opcode = lnkFf.opcode;
            nxt_core.req.addr = lnkFf.addr;
            nxt_core.req.data = lnkFf.wrData;
            nxt_core.req.dataCnt = lnkFf.dataCnt;
            // mode flag kept apart from quad enable bit
            if (lnkFf.opcode == `SFD_OP_QUAD_ENTER)
               nxt_core.quad = 1'b1;
            if (lnkFf.opcode == `SFD_OP_QUAD_EXIT)
               nxt_core.quad = 1'b0;
            nxt_core.pause = lnkFf.opcode inside {`SFD_OP_PAUSE_A, `SFD_OP_PAUSE_B};
            nxt_core.cont = lnkFf.opcode inside {`SFD_OP_CONT_A, `SFD_OP_CONT_B};
            nxt_core.memReset = (lnkFf.opcode == `SFD_OP_RESET_MEM) && coreFf.armed;
            nxt_core.armed = lnkFf.opcode == `SFD_OP_RESET_ARM;
         end
      end
   end

   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
         coreFf <= '0;
      else
         coreFf <= nxt_core;
   end

   assign sioOut = drvFf.out;
   assign sioOe = drvFf.oe;
   assign quadMode = coreFf.quad;
   assign cmdValid = coreFf.cmdValid;
   assign cmdReq = coreFf.req;
   assign cmdReject = coreFf.reject;
   assign pauseReq = coreFf.pause;
   assign continueReq = coreFf.cont;
   assign memReset = coreFf.memReset;
endmodule
`default_nettype wire

/* common/sfd_map.svh */
`ifndef SFD_MAP_SVH
`define SFD_MAP_SVH
`define SFD_OP_READ 8'h03
`define SFD_OP_FAST 8'h0B
`define SFD_OP_DUAL_IO 8'hBB
`define SFD_OP_DUAL_OUT 8'h3B
`define SFD_OP_QUAD_IO 8'hEB
`define SFD_OP_QUAD_OUT 8'h6B
`define SFD_OP_QUAD_WAIT 8'hE7
`define SFD_OP_PROG 8'h02
`define SFD_OP_QUAD_PROG 8'h38
`define SFD_OP_SECT_ERASE 8'h20
`define SFD_OP_HALF_BLK 8'h52
`define SFD_OP_BLK_ERASE 8'hD8
`define SFD_OP_CHIP_ERASE_A 8'h60
`define SFD_OP_CHIP_ERASE_B 8'hC7
`define SFD_OP_WR_EN 8'h06
`define SFD_OP_WR_DIS 8'h04
`define SFD_OP_PROT_SEL 8'h68
`define SFD_OP_QUAD_ENTER 8'h35
`define SFD_OP_QUAD_EXIT 8'hF5
`define SFD_OP_PAUSE_A 8'h75
`define SFD_OP_PAUSE_B 8'hB0
`define SFD_OP_CONT_A 8'h7A
`define SFD_OP_CONT_B 8'h30
`define SFD_OP_POWER_DOWN 8'hB9
`define SFD_OP_NOP 8'h00
`define SFD_OP_RESET_ARM 8'h66
`define SFD_OP_RESET_MEM 8'h99
`define SFD_OP_GANG_LOCK 8'h7E
`define SFD_OP_GANG_UNLOCK 8'h98
`define SFD_OP_FACT_EN 8'h41
`define SFD_OP_ID 8'h9F
`define SFD_OP_SIG 8'hAB
`define SFD_OP_MAKER_PART 8'h90
`define SFD_OP_QUAD_ID 8'hAF
`define SFD_OP_TABLE 8'h5A
`define SFD_OP_STAT_RD 8'h05
`define SFD_OP_CFG_RD 8'h15
`define SFD_OP_FACT_STATE 8'h44
`define SFD_OP_STAT_WR 8'h01
`define SFD_OP_SEC_RD 8'h2B
`define SFD_OP_SEC_WR 8'h2F
`define SFD_OP_BURST 8'hC0
`define SFD_OP_OTP_ENTER 8'hB1
`define SFD_OP_OTP_EXIT 8'hC1
`define SFD_OP_LOCK_WR 8'h2C
`define SFD_OP_LOCK_RD 8'h2D
`define SFD_OP_PPROT_WR 8'hE3
`define SFD_OP_PPROT_CLR 8'hE4
`define SFD_OP_PPROT_RD 8'hE2
`define SFD_OP_DPROT_WR 8'hE1
`define SFD_OP_DPROT_RD 8'hE0
`define SFD_ADDR_NONE 3'h0
`define SFD_ADDR_ONE 3'h1
`define SFD_ADDR_THREE 3'h3
`define SFD_ADDR_FOUR 3'h4
`define SFD_DUM_NONE 5'h00
`define SFD_DUM_FAST 5'h08
`define SFD_DUM_DUAL_IO 5'h04
`define SFD_DUM_QUAD_IO 5'h06
`define SFD_DUM_WAIT 5'h04
`define SFD_DUM_SIG 5'h18
`define SFD_DUM_MAKER 5'h10
`define SFD_DUM_TABLE 5'h08
`define SFD_DUM_SEL1 5'h06
`define SFD_DUM_SEL2 5'h08
`define SFD_DUM_SEL3 5'h0A
`define SFD_LAST_BIT_1 3'h7
`define SFD_LAST_BIT_2 3'h3
`define SFD_LAST_BIT_4 3'h1
`endif

/* common/sfd_pkg.sv */
package sfd_pkg;
   typedef enum logic [1:0] {SFD_LN1, SFD_LN2, SFD_LN4} sfd_lane_t;
   typedef enum logic [1:0] {SFD_DIR_NONE, SFD_DIR_IN, SFD_DIR_OUT} sfd_dir_t;
   typedef enum logic [2:0] {SFD_PH_CMD, SFD_PH_ADDR, SFD_PH_DUMMY, SFD_PH_DATA, SFD_PH_DONE,
      SFD_PH_IDLE} sfd_phase_t;
   typedef struct packed {
      logic known;
      logic alignReq;
      logic [2:0] addrBytes;
      logic [4:0] dummy;
      sfd_dir_t dir;
      sfd_lane_t addrLanes;
      sfd_lane_t dataLanes;
   } sfd_cmd_t;
   typedef struct packed {
      logic [7:0] opcode;
      logic [31:0] addr;
      logic [7:0] data;
      logic [8:0] dataCnt;
   } sfd_req_t;
   typedef struct packed {
      sfd_phase_t phase;
      logic frameTgl;
      logic [2:0] bitCnt;
      logic [2:0] byteCnt;
      logic [4:0] dummyCnt;
      logic [7:0] opcode;
      sfd_cmd_t cmd;
      logic [31:0] addr;
      logic [7:0] wrData;
      logic [8:0] dataCnt;
   } sfd_lnk_t;
   typedef struct packed {
      logic [3:0] out;
      logic [3:0] oe;
      logic [7:0] shift;
      logic [2:0] cnt;
   } sfd_drv_t;
   typedef struct packed {
      logic csPrev;
      logic seenTgl;
      logic quad;
      logic armed;
      logic cmdValid;
      logic reject;
      logic pause;
      logic cont;
      logic memReset;
      sfd_req_t req;
   } sfd_core_t;
endpackage

/* rtl/sfd_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module sfd_sync
#(
   parameter int WIDTH = 1
)
(
   input wire logic clock,
   input wire logic rst_b,
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);
   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] hold;
   } sfd_sync_st_t;
   sfd_sync_st_t syncFf;
   sfd_sync_st_t nxt_sync;

   always_comb
   begin
      nxt_sync.meta = din;
      nxt_sync.hold = syncFf.meta;
   end

   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
         syncFf <= '0;
      else
         syncFf <= nxt_sync;
   end

   assign dout = syncFf.hold;
endmodule
`default_nettype wire

/* rtl/sfd_cmd_table.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sfd_map.svh"
module sfd_cmd_table
(
   input wire logic [7:0] opcode,
   input wire logic quadMode,
   input wire logic [1:0] dummySel,
   output sfd_pkg::sfd_cmd_t cmd
);
   function automatic sfd_pkg::sfd_cmd_t mk(input logic [2:0] a, input logic [4:0] d,
      input sfd_pkg::sfd_dir_t dir, input logic al);
      sfd_pkg::sfd_cmd_t c;
      c.known = 1'b1;
      c.alignReq = al;
      c.addrBytes = a;
      c.dummy = d;
      c.dir = dir;
      c.addrLanes = sfd_pkg::SFD_LN1;
      c.dataLanes = sfd_pkg::SFD_LN1;
      return c;
   endfunction

   function automatic logic [4:0] cfg(input logic [4:0] dflt, input logic [1:0] sel);
      logic [4:0] d;
      d = dflt;
      unique case (sel)
         2'h0: d = dflt;
         2'h1: d = `SFD_DUM_SEL1;
         2'h2: d = `SFD_DUM_SEL2;
         2'h3: d = `SFD_DUM_SEL3;
      endcase
      return d;
   endfunction

   logic singleOnly;
   logic quadOnly;
   sfd_pkg::sfd_cmd_t c;

   always_comb
   begin
      c = '0;
      case (opcode)
         `SFD_OP_READ: c = mk(`SFD_ADDR_THREE, `SFD_DUM_NONE, sfd_pkg::SFD_DIR_OUT, 1'b0);
         `SFD_OP_FAST: c = mk(`SFD_ADDR_THREE, cfg(`SFD_DUM_FAST, dummySel),
            sfd_pkg::SFD_DIR_OUT, 1'b0);
         `SFD_OP_DUAL_IO, `SFD_OP_DUAL_OUT:
         begin
            c = mk(`SFD_ADDR_THREE, cfg((opcode == `SFD_OP_DUAL_IO) ? `SFD_DUM_DUAL_IO :
               `SFD_DUM_FAST, dummySel), sfd_pkg::SFD_DIR_OUT, 1'b0);
            c.dataLanes = sfd_pkg::SFD_LN2;
            if (opcode == `SFD_OP_DUAL_IO)
               c.addrLanes = sfd_pkg::SFD_LN2;
         end
         `SFD_OP_QUAD_IO, `SFD_OP_QUAD_OUT:
         begin
            c = mk(`SFD_ADDR_THREE, cfg((opcode == `SFD_OP_QUAD_IO) ? `SFD_DUM_QUAD_IO :
               `SFD_DUM_FAST, dummySel), sfd_pkg::SFD_DIR_OUT, 1'b0);
            c.dataLanes = sfd_pkg::SFD_LN4;
            if (opcode == `SFD_OP_QUAD_IO)
               c.addrLanes = sfd_pkg::SFD_LN4;
         end
         `SFD_OP_QUAD_WAIT:
         begin
            c = mk(`SFD_ADDR_THREE, `SFD_DUM_WAIT, sfd_pkg::SFD_DIR_OUT, 1'b0);
            c.addrLanes = sfd_pkg::SFD_LN4;
            c.dataLanes = sfd_pkg::SFD_LN4;
         end
         `SFD_OP_PROG, `SFD_OP_STAT_WR, `SFD_OP_SEC_WR, `SFD_OP_BURST, `SFD_OP_LOCK_WR:
            c = mk((opcode == `SFD_OP_PROG) ? `SFD_ADDR_THREE : `SFD_ADDR_NONE, `SFD_DUM_NONE,
               sfd_pkg::SFD_DIR_IN, 1'b1);
         `SFD_OP_QUAD_PROG:
         begin
            c = mk(`SFD_ADDR_THREE, `SFD_DUM_NONE, sfd_pkg::SFD_DIR_IN, 1'b1);
            c.addrLanes = sfd_pkg::SFD_LN4;
            c.dataLanes = sfd_pkg::SFD_LN4;
         end
         `SFD_OP_SECT_ERASE, `SFD_OP_HALF_BLK, `SFD_OP_BLK_ERASE:
            c = mk(`SFD_ADDR_THREE, `SFD_DUM_NONE, sfd_pkg::SFD_DIR_NONE, 1'b1);
         `SFD_OP_CHIP_ERASE_A, `SFD_OP_CHIP_ERASE_B, `SFD_OP_WR_EN, `SFD_OP_WR_DIS,
         `SFD_OP_PROT_SEL, `SFD_OP_QUAD_ENTER, `SFD_OP_QUAD_EXIT, `SFD_OP_PAUSE_A,
         `SFD_OP_PAUSE_B, `SFD_OP_CONT_A, `SFD_OP_CONT_B, `SFD_OP_POWER_DOWN, `SFD_OP_NOP,
         `SFD_OP_RESET_ARM, `SFD_OP_RESET_MEM, `SFD_OP_GANG_LOCK, `SFD_OP_GANG_UNLOCK,
         `SFD_OP_FACT_EN, `SFD_OP_OTP_ENTER, `SFD_OP_OTP_EXIT, `SFD_OP_PPROT_CLR:
            c = mk(`SFD_ADDR_NONE, `SFD_DUM_NONE, sfd_pkg::SFD_DIR_NONE, 1'b1);
         `SFD_OP_ID, `SFD_OP_QUAD_ID, `SFD_OP_STAT_RD, `SFD_OP_CFG_RD, `SFD_OP_FACT_STATE,
         `SFD_OP_SEC_RD, `SFD_OP_LOCK_RD:
            c = mk(`SFD_ADDR_NONE, `SFD_DUM_NONE, sfd_pkg::SFD_DIR_OUT, 1'b0);
         `SFD_OP_SIG: c = mk(`SFD_ADDR_NONE, `SFD_DUM_SIG, sfd_pkg::SFD_DIR_OUT, 1'b0);
         `SFD_OP_MAKER_PART: c = mk(`SFD_ADDR_ONE, `SFD_DUM_MAKER, sfd_pkg::SFD_DIR_OUT, 1'b0);
         `SFD_OP_TABLE: c = mk(`SFD_ADDR_THREE, `SFD_DUM_TABLE, sfd_pkg::SFD_DIR_OUT, 1'b0);
         `SFD_OP_PPROT_WR, `SFD_OP_DPROT_WR:
            c = mk(`SFD_ADDR_FOUR, `SFD_DUM_NONE, sfd_pkg::SFD_DIR_IN, 1'b1);
         `SFD_OP_PPROT_RD, `SFD_OP_DPROT_RD:
            c = mk(`SFD_ADDR_FOUR, `SFD_DUM_NONE, sfd_pkg::SFD_DIR_OUT, 1'b0);
         default: c = '0;
      endcase
   end

   assign singleOnly = opcode inside {`SFD_OP_READ, `SFD_OP_FAST, `SFD_OP_DUAL_IO,
      `SFD_OP_DUAL_OUT, `SFD_OP_QUAD_OUT, `SFD_OP_QUAD_WAIT, `SFD_OP_QUAD_PROG,
      `SFD_OP_QUAD_ENTER, `SFD_OP_ID, `SFD_OP_MAKER_PART, `SFD_OP_TABLE, `SFD_OP_LOCK_WR,
      `SFD_OP_LOCK_RD, `SFD_OP_PPROT_WR, `SFD_OP_PPROT_CLR, `SFD_OP_PPROT_RD,
      `SFD_OP_DPROT_WR, `SFD_OP_DPROT_RD};
   assign quadOnly = opcode inside {`SFD_OP_QUAD_EXIT, `SFD_OP_QUAD_ID};

   always_comb
   begin
      cmd = c;
      if ((quadMode && singleOnly) || (!quadMode && quadOnly))
         cmd = '0;
      if (quadMode)
      begin
         cmd.addrLanes = sfd_pkg::SFD_LN4;
         cmd.dataLanes = sfd_pkg::SFD_LN4;
      end
   end
endmodule
`default_nettype wire

/* verification/sfd_decoder_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module sfd_decoder_sva
(
   input wire logic clock,
   input wire logic rst_b,
   input wire logic cs_b,
   input wire logic [3:0] sioOe,
   input wire logic quadMode,
   input wire logic cmdValid,
   input wire sfd_pkg::sfd_req_t cmdReq,
   input wire logic cmdReject,
   input wire logic pauseReq,
   input wire logic continueReq,
   input wire logic memReset
);
   logic armed_ff;
   default clocking dcb @(posedge clock);
   endclocking
   default disable iff (!rst_b);
   sequence s_mode_cmd;
      cmdValid && (cmdReq.opcode == 8'h35 || cmdReq.opcode == 8'hF5);
   endsequence
   sequence s_closed;
      $past(cs_b, 2) && $past(cs_b) && cs_b;
   endsequence
   // arming follows the last judged frame
   always_ff @(posedge clock or negedge rst_b)
      if (!rst_b)
         armed_ff <= 1'b0;
      else if (cmdValid | cmdReject)
         armed_ff <= cmdValid && cmdReq.opcode == 8'h66;
   a_quad_enter: assert property (cmdValid && cmdReq.opcode == 8'h35 |-> quadMode)
      else $error("no quad entry");
   a_quad_leave: assert property (cmdValid && cmdReq.opcode == 8'hF5 |->
      !quadMode && $past(quadMode))
      else $error("bad quad exit");
   a_mode_hold: assert property ($changed(quadMode) |-> s_mode_cmd)
      else $error("mode moved");
   a_pause_codes: assert property (pauseReq ==
      (cmdValid && (cmdReq.opcode == 8'h75 || cmdReq.opcode == 8'hB0)))
      else $error("pause wrong");
   a_cont_codes: assert property (continueReq ==
      (cmdValid && (cmdReq.opcode == 8'h7A || cmdReq.opcode == 8'h30)))
      else $error("continue wrong");
   a_reset_pair: assert property (memReset |->
      cmdValid && cmdReq.opcode == 8'h99 && armed_ff)
      else $error("reset unarmed");
   a_oe_quiet: assert property (cs_b && $past(cs_b) |-> sioOe == 4'h0)
      else $error("drive when idle");
   a_result_late: assert property (cmdValid || cmdReject |-> s_closed)
      else $error("early result");
endmodule
bind sfd_decoder sfd_decoder_sva sfd_decoder_sva_i (.clock(clock), .rst_b(rst_b), .cs_b(cs_b),
   .sioOe(sioOe), .quadMode(quadMode), .cmdValid(cmdValid), .cmdReq(cmdReq),
   .cmdReject(cmdReject), .pauseReq(pauseReq), .continueReq(continueReq), .memReset(memReset));
`default_nettype wire

/* verification/sfd_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module sfd_host_model
(
   output logic sclk,
   output logic cs_b,
   output logic [3:0] sio
);
   initial
   begin
      sclk = 1'b0;
      cs_b = 1'b1;
      sio = 4'h0;
   end
   // n units of v, msb first
   task automatic shift(input logic q, input int n, input logic [31:0] v);
      for (int i = n - 1; i >= 0; i--)
      begin
         sio = q ? v[i*4 +: 4] : {~sio[3:1], v[i]};
         #16 sclk = 1'b1;
         #16 sclk = 1'b0;
      end
   endtask
   task automatic frame(input logic q, input logic [7:0] op, input int na, input int ex);
      cs_b = 1'b0;
      shift(q, q ? 2 : 8, {24'h0, op});
      shift(q, q ? na * 2 : na * 8, 32'h123456);
      shift(q, ex, 32'h0);
      #16 cs_b = 1'b1;
      sio = ~sio;
   endtask
endmodule
`default_nettype wire

/* verification/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
   $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module tb_top;
   logic clock = 1'b0;
   logic rst_b = 1'b0;
   logic sclk, cs_b, quadMode, cmdValid, cmdReject, pauseReq, continueReq, memReset;
   logic [3:0] sio, sioOut, sioOe;
   logic [1:0] dummySel = 2'h0;
   logic [1:0] res;
   logic gotP, gotC, gotM, drove;
   logic [7:0] rdBits, rdQuad;
   logic [7:0] readVal = 8'hA5;
   int nQuad;
   logic [7:0] codes [4] = '{8'h75, 8'hB0, 8'h7A, 8'h30};
   sfd_pkg::sfd_req_t cmdReq;
   int miscompares = 0;
   int num_checks = 0;
   always #20 clock = ~clock;
   // read data capture on the sampling edge
   always @(posedge sclk)
   begin
      if (sioOe[1] === 1'b1)
      begin
         drove = 1'b1;
         rdBits = {rdBits[6:0], sioOut[1]};
      end
      if (sioOe === 4'hF)
      begin
         nQuad++;
         rdQuad = {rdQuad[3:0], sioOut};
      end
   end
   sfd_host_model sfd_host_model_i (.sclk(sclk), .cs_b(cs_b), .sio(sio));
   sfd_decoder sfd_decoder_i (.clock(clock), .rst_b(rst_b), .sclk(sclk), .cs_b(cs_b),
      .sioIn(sio), .sioOut(sioOut), .sioOe(sioOe), .dummySel(dummySel), .readByte(readVal),
      .quadMode(quadMode), .cmdValid(cmdValid), .cmdReq(cmdReq), .cmdReject(cmdReject),
      .pauseReq(pauseReq), .continueReq(continueReq), .memReset(memReset));
   task automatic tally_and_finish;
      if (miscompares == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // one frame, then the judged result; exp 1 accept, 2 refuse, 3 either
   task automatic run(input logic q, input logic [7:0] op, input int na, input int ex,
      input logic [1:0] exp);
      {res, gotP, gotC, gotM, drove} = '0;
      {rdBits, rdQuad} = 16'h0000;
      nQuad = 0;
      @(negedge clock);
      sfd_host_model_i.frame(q, op, na, ex);
      repeat (8)
      begin
         @(posedge clock);
         #1;
         if (cmdValid | cmdReject)
            {res, gotP, gotC, gotM} = {cmdReject, cmdValid, pauseReq, continueReq, memReset};
      end
      if (exp != 2'h3)
         `CHK(res, exp)
   endtask
   task automatic t_single;
      `CHK(quadMode, 1'b0)
      run(0, 8'hF5, 0, 0, 2'h2);
      run(0, 8'h52, 3, 0, 2'h1);
      `CHK(cmdReq.addr[23:0], 24'h123456)
      run(0, 8'h90, 1, 24, 2'h1);
      `CHK(rdBits, readVal)
      run(0, 8'hE4, 0, 0, 2'h1);
      run(0, 8'h02, 3, 16, 2'h1);
      `CHK(cmdReq.dataCnt, 9'h002)
      run(0, 8'h06, 0, 3, 2'h2);
      run(0, 8'hFF, 0, 0, 2'h2);
   endtask
   task automatic t_dummy;
      run(0, 8'h0B, 3, 16, 2'h1);
      `CHK(drove, 1'b1)
      `CHK(rdBits, readVal)
      @(negedge clock) dummySel = 2'h3;
      run(0, 8'h0B, 3, 9, 2'h1);
      `CHK(drove, 1'b0)
      run(0, 8'hE7, 3, 6, 2'h1);
      `CHK(nQuad, 3 * 8 + 6 - 3 * 2 - 4)
      @(negedge clock) dummySel = 2'h0;
   endtask
   task automatic t_quad;
      run(0, 8'h35, 0, 0, 2'h1);
      `CHK(quadMode, 1'b1)
      run(1, 8'h0B, 3, 0, 2'h2);
      run(1, 8'hE4, 0, 0, 2'h2);
      run(1, 8'h52, 3, 0, 2'h1);
      `CHK(cmdReq.addr[23:0], 24'h123456)
      for (int k = 0; k < 4; k++)
      begin
         run(1, codes[k], 0, 0, 2'h1);
         `CHK({gotP, gotC}, k < 2 ? 2'h2 : 2'h1)
      end
      run(1, 8'h44, 0, 2, 2'h1);
      `CHK(rdQuad, readVal)
      `CHK(cmdReq.opcode, 8'h44)
      run(1, 8'hF5, 0, 0, 2'h1);
      `CHK(quadMode, 1'b0)
      run(0, 8'h06, 0, 0, 2'h1);
   endtask
   task automatic t_reset_pair;
      run(0, 8'h66, 0, 0, 2'h1);
      run(0, 8'h99, 0, 0, 2'h1);
      `CHK(gotM, 1'b1)
      run(0, 8'h66, 0, 0, 2'h1);
      run(0, 8'h00, 0, 0, 2'h1);
      run(0, 8'h99, 0, 0, 2'h3);
      `CHK(gotM, 1'b0)
   endtask
   initial
   begin
      repeat (5) @(negedge clock);
      rst_b = 1'b1;
      repeat (2) @(negedge clock);
      t_single();
      t_dummy();
      t_quad();
      t_reset_pair();
      tally_and_finish();
   end
   initial
   begin
      #500us;
      miscompares++;
      tally_and_finish();
   end
endmodule
`default_nettype wire
